// *** rtl/ptb_defines.svh ***
`ifndef PTB_DEFINES_SVH
`define PTB_DEFINES_SVH

// Register offsets (word addresses on the plain port)
`define PTB_ADDR_CONTROL   4'h0
`define PTB_ADDR_COUNT     4'h1
`define PTB_ADDR_PERIOD    4'h2
`define PTB_ADDR_INT_STAT  4'h3
`define PTB_ADDR_INT_MASK  4'h4

// Control register field positions
`define PTB_CTL_MODE_LO    0
`define PTB_CTL_CKPS_LO    2
`define PTB_CTL_OPS_LO     4
`define PTB_CTL_ENABLE     15

// Count register direction flag position
`define PTB_CNT_DIR        15

// Reset values
`define PTB_RST_CONTROL    16'h0000
`define PTB_RST_PERIOD     15'h0000
`define PTB_RST_MASK       2'h0

// Prescaler terminal counts (ratio minus one)
`define PTB_PRE_DIV1       6'h00
`define PTB_PRE_DIV4       6'h03
`define PTB_PRE_DIV16      6'h0f
`define PTB_PRE_DIV64      6'h3f

`endif

// *** rtl/ptb_pkg.sv ***
package ptb_pkg;
  // Time base operating modes
  typedef enum logic [1:0] {
    PTB_FREE_RUN,
    PTB_SINGLE_SHOT,
    PTB_UP_DOWN,
    PTB_UP_DOWN_DBL
  } ptb_mode_e;

  typedef logic [14:0] ptb_count_t;
endpackage

// *** rtl/ptb_prescaler.sv ***
`timescale 1ns/1ps
`include "ptb_defines.svh"

// Divides the instruction clock into one-cycle count enables
module ptb_prescaler #(
  parameter int WIDTH = 6
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  output logic            tick
);
  logic [WIDTH-1:0] cnt_q;   // Divider count
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] limit;   // Terminal count for ratio

  // Ratio decode and next count
  always_comb begin
    case (ratio_sel)
      2'h0:    limit = WIDTH'(`PTB_PRE_DIV1);
      2'h1:    limit = WIDTH'(`PTB_PRE_DIV4);
      2'h2:    limit = WIDTH'(`PTB_PRE_DIV16);
      default: limit = WIDTH'(`PTB_PRE_DIV64);
    endcase
    tick  = (cnt_q >= limit) && !clear;
    if (clear || cnt_q >= limit) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + WIDTH'(1);
    end
  end

  // Divider register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** rtl/ptb_time_base.sv ***
`timescale 1ns/1ps
`include "ptb_defines.svh"

// Operation
// - 15-bit prescaled counter, postscaled, readable count
// - Count bit 15 reads direction, down is 1
// - Enable starts/stops; clearing keeps count
// - Period match reloads zero or reverses
// - Zero period stops counting and events
// - Zero active period blocks transfer until disabled
// - Two-bit mode selects four modes
// - Mode and postscaler decide event rate
// - Free-run counts up, wraps to zero
// - Free-run event each match, postscaled
// - Single-shot wraps then hardware clears enable
// - Single-shot one event, postscaler ignored
// - Mode 10 event at zero turning up
// - Mode 11 events at zero and match
// - Prescaler ratios 1, 4, 16, 64
// - Four-bit postscaler divides one to sixteen
module ptb_time_base (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             tb_event,
  output logic             irq
);
  import ptb_pkg::*;

  logic [15:0]  ctl_q;         // Control register
  logic [15:0]  ctl_d;
  ptb_count_t   cnt_q;         // Time base count
  ptb_count_t   cnt_d;
  logic         dir_q;         // Count direction, 1 while down
  logic         dir_d;
  ptb_count_t   per_buf_q;     // Software-written period buffer
  ptb_count_t   per_buf_d;
  ptb_count_t   per_q;         // Active period
  ptb_count_t   per_d;
  logic [3:0]   post_q;        // Postscaler count
  logic [3:0]   post_d;
  logic         evt_q;         // Event pulse register
  logic         evt_d;
  logic [1:0]   stat_q;        // Sticky status: event, shot done
  logic [1:0]   stat_d;
  logic [1:0]   mask_q;        // Interrupt mask
  logic [1:0]   mask_d;
  logic [15:0]  rdata_q;       // Read data
  logic [15:0]  rdata_d;
  logic         irq_q;         // Interrupt level
  logic         irq_d;
  logic         tick;          // Prescaled count enable
  logic         pre_clr;       // Prescaler clear
  logic         enable;
  ptb_mode_e    mode;
  logic         match;
  logic         raw_evt;       // Event before postscaler
  logic         post_evt;      // Event after postscaler
  logic         uses_post;     // Postscaler applies
  logic         shot_done;

  // Decode one address against a read or write strobe
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off,
                               input logic s);
    return s && (a == off);
  endfunction

  assign enable  = ctl_q[`PTB_CTL_ENABLE];
  assign mode    = ptb_mode_e'(ctl_q[`PTB_CTL_MODE_LO +: 2]);
  // Prescaler cleared on count or control writes
  assign pre_clr = hit(reg_addr, `PTB_ADDR_COUNT, reg_wr) ||
                   hit(reg_addr, `PTB_ADDR_CONTROL, reg_wr);

  ptb_prescaler #(
    .WIDTH (6)
  ) u_pre (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (pre_clr),
    .ratio_sel (ctl_q[`PTB_CTL_CKPS_LO +: 2]),
    .tick      (tick)
  );

  // Counter, direction, period and event logic
  always_comb begin
    ctl_d     = ctl_q;
    cnt_d     = cnt_q;
    dir_d     = dir_q;
    per_buf_d = per_buf_q;
    per_d     = per_q;
    post_d    = post_q;
    raw_evt   = 1'b0;
    shot_done = 1'b0;
    uses_post = 1'b0;
    match     = (cnt_q == per_q) && (per_q != 15'h0000);
    // Up-only modes always show the upward flag
    if (mode == PTB_FREE_RUN || mode == PTB_SINGLE_SHOT) begin
      dir_d = 1'b0;
    end
    case (mode)
      PTB_FREE_RUN:    uses_post = 1'b1;
      PTB_UP_DOWN:     uses_post = 1'b1;
      default:         uses_post = 1'b0;
    endcase
    // Zero period halts everything
    if (enable && tick && per_q != 15'h0000) begin
      case (mode)
        PTB_FREE_RUN: begin
          dir_d = 1'b0;
          if (match) begin
            cnt_d   = '0;
            raw_evt = 1'b1;
            per_d   = per_buf_q;
          end else begin
            cnt_d = cnt_q + 15'h0001;
          end
        end
        PTB_SINGLE_SHOT: begin
          dir_d = 1'b0;
          if (match) begin
            cnt_d     = '0;
            ctl_d[`PTB_CTL_ENABLE] = 1'b0;
            raw_evt   = 1'b1;
            shot_done = 1'b1;
            per_d     = per_buf_q;
          end else begin
            cnt_d = cnt_q + 15'h0001;
          end
        end
        default: begin
          // Up/down modes
          if (!dir_q) begin
            if (match) begin
              dir_d = 1'b1;
              cnt_d = cnt_q - 15'h0001;
              if (mode == PTB_UP_DOWN_DBL) begin
                raw_evt = 1'b1;
              end
            end else begin
              cnt_d = cnt_q + 15'h0001;
            end
          end else if (cnt_q == 15'h0001 || cnt_q == 15'h0000) begin
            cnt_d   = '0;
            dir_d   = 1'b0;
            raw_evt = 1'b1;
            per_d   = per_buf_q;
          end else begin
            cnt_d = cnt_q - 15'h0001;
          end
        end
      endcase
    end
    // Period transfer never leaves a zero active period while running
    if (per_q == 15'h0000 && enable) begin
      per_d = per_q;
    end
    if (!enable) begin
      per_d = per_buf_q;
    end
    // Postscaler gate
    post_evt = 1'b0;
    if (raw_evt) begin
      if (!uses_post || post_q >= ctl_q[`PTB_CTL_OPS_LO +: 4]) begin
        post_evt = 1'b1;
        post_d   = '0;
      end else begin
        post_d = post_q + 4'h1;
      end
    end
    // Software writes
    if (hit(reg_addr, `PTB_ADDR_CONTROL, reg_wr)) begin
      ctl_d  = reg_wdata;
      post_d = '0;
    end
    if (hit(reg_addr, `PTB_ADDR_COUNT, reg_wr)) begin
      cnt_d  = reg_wdata[14:0];
      post_d = '0;
    end
    if (hit(reg_addr, `PTB_ADDR_PERIOD, reg_wr)) begin
      per_buf_d = reg_wdata[14:0];
    end
    evt_d = post_evt;
  end

  // Status, mask, read data, interrupt
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (hit(reg_addr, `PTB_ADDR_INT_STAT, reg_rd)) begin
      stat_d = 2'h0;
    end
    // Set wins over read clear
    stat_d = stat_d | {shot_done, post_evt};
    if (hit(reg_addr, `PTB_ADDR_INT_MASK, reg_wr)) begin
      mask_d = reg_wdata[1:0];
    end
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PTB_ADDR_CONTROL:  rdata_d = ctl_q;
        `PTB_ADDR_COUNT:    rdata_d = {dir_q, cnt_q};
        `PTB_ADDR_PERIOD:   rdata_d = {1'b0, per_buf_q};
        `PTB_ADDR_INT_STAT: rdata_d = {14'h0000, stat_q};
        `PTB_ADDR_INT_MASK: rdata_d = {14'h0000, mask_q};
        default:            rdata_d = 16'h0000;
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end

  // State registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q     <= `PTB_RST_CONTROL;
      cnt_q     <= '0;
      dir_q     <= 1'b0;
      per_buf_q <= `PTB_RST_PERIOD;
      per_q     <= `PTB_RST_PERIOD;
      post_q    <= '0;
      evt_q     <= 1'b0;
      stat_q    <= 2'h0;
      mask_q    <= `PTB_RST_MASK;
      rdata_q   <= 16'h0000;
      irq_q     <= 1'b0;
    end else begin
      ctl_q     <= ctl_d;
      cnt_q     <= cnt_d;
      dir_q     <= dir_d;
      per_buf_q <= per_buf_d;
      per_q     <= per_d;
      post_q    <= post_d;
      evt_q     <= evt_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign tb_event  = evt_q;
  assign irq       = irq_q;

  // Checks
  property p_zero_period_holds;
    @(posedge sys_clk) disable iff (rst)
      (per_q == 15'h0000 && !reg_wr) |=> $stable(cnt_q);
  endproperty
  a_zero_period_holds: assert property (p_zero_period_holds)
    else $error("count moved with zero period");

  property p_free_wrap;
    @(posedge sys_clk) disable iff (rst)
      (enable && tick && match && mode == PTB_FREE_RUN && !reg_wr) |=> cnt_q == '0;
  endproperty
  a_free_wrap: assert property (p_free_wrap)
    else $error("free run did not wrap");

  property p_shot_stop;
    @(posedge sys_clk) disable iff (rst)
      (enable && tick && match && mode == PTB_SINGLE_SHOT && !reg_wr) |=> !enable;
  endproperty
  a_shot_stop: assert property (p_shot_stop)
    else $error("single shot did not clear enable");

  property p_disabled_hold;
    @(posedge sys_clk) disable iff (rst)
      (!enable && !reg_wr) |=> $stable(cnt_q);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("count moved while disabled");

  property p_event_pulse;
    @(posedge sys_clk) disable iff (rst)
      post_evt |=> tb_event ##1 !tb_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("event not a one-cycle pulse");

  property p_dir_read;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == `PTB_ADDR_COUNT) |=> reg_rdata[15] == $past(dir_q);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction flag misread");

  property p_shot_nopost;
    @(posedge sys_clk) disable iff (rst)
      (raw_evt && mode == PTB_SINGLE_SHOT) |-> post_evt;
  endproperty
  a_shot_nopost: assert property (p_shot_nopost)
    else $error("postscaler applied in single shot");

  property p_updown_reverse;
    @(posedge sys_clk) disable iff (rst)
      (enable && tick && match && !dir_q && mode[1] && !reg_wr) |=> dir_q;
  endproperty
  a_updown_reverse: assert property (p_updown_reverse)
    else $error("up/down did not reverse at match");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst)
      (|(stat_q & mask_q)) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with unmasked status");

  property p_up_only_dir;
    @(posedge sys_clk) disable iff (rst)
      (mode == PTB_FREE_RUN || mode == PTB_SINGLE_SHOT) |=> !dir_q;
  endproperty
  a_up_only_dir: assert property (p_up_only_dir)
    else $error("direction flag set in an up-only mode");

  property p_zero_period_kept;
    @(posedge sys_clk) disable iff (rst)
      (enable && per_q == 15'h0000) |=> per_q == 15'h0000;
  endproperty
  a_zero_period_kept: assert property (p_zero_period_kept)
    else $error("zero period replaced while enabled");

  property p_count_step;
    @(posedge sys_clk) disable iff (rst)
      (enable && tick && !match && !dir_q && per_q != 15'h0000 && !reg_wr)
        |=> cnt_q == $past(cnt_q) + 15'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step up by one");

  // Bottom of an up/down sweep: event now, upward from zero next
  sequence s_at_bottom;
    enable && tick && mode[1] && dir_q && cnt_q == 15'h0001 && per_q != 15'h0000 && !reg_wr;
  endsequence
  sequence s_turned_up;
    cnt_q == 15'h0000 && !dir_q;
  endsequence
  property p_bottom_turn;
    @(posedge sys_clk) disable iff (rst)
      s_at_bottom |-> raw_evt ##1 s_turned_up;
  endproperty
  a_bottom_turn: assert property (p_bottom_turn)
    else $error("up/down did not turn at zero with event");

  property p_dbl_match_event;
    @(posedge sys_clk) disable iff (rst)
      (enable && tick && match && !dir_q && mode == PTB_UP_DOWN_DBL) |-> post_evt;
  endproperty
  a_dbl_match_event: assert property (p_dbl_match_event)
    else $error("double update missed match event");
endmodule

// *** testbench/ptb_irq_ctl_model.sv ***
`timescale 1ns/1ps

// Interrupt controller stand-in: tallies event pulses from the time base
module ptb_irq_ctl_model (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   clr,
  input  wire logic   tb_event,
  output logic [15:0] n_events
);
  // One tally per sampled pulse; a stretched pulse would count twice
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      n_events <= 16'h0000;
    end else if (clr) begin
      n_events <= 16'h0000;
    end else if (tb_event) begin
      n_events <= n_events + 16'h0001;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "ptb_defines.svh"

module tb_top;
  import ptb_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        tb_event;
  logic        irq;
  logic        clr       = 1'b0;
  logic [15:0] nev;
  logic [15:0] rv;
  logic [15:0] up;
  logic [15:0] dn;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  // Clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  ptb_time_base dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tb_event(tb_event), .irq(irq));

  ptb_irq_ctl_model u_ic (.sys_clk(sys_clk), .rst(rst), .clr(clr),
    .tb_event(tb_event), .n_events(nev));

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read into rv; data stands only in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  // Read and compare
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk(rv, e);
  endtask

  // Clear the event tally, wait n cycles, compare
  task automatic win(input int n, input logic [15:0] e);
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    chk(nev, e);
  endtask

  function automatic logic [15:0] ctl(input logic en, input ptb_mode_e m,
                                      input logic [1:0] ps, input logic [3:0] os);
    return {en, 7'h00, os, ps, m};
  endfunction

  // Disable, zero the count, load period, enable
  task automatic start(input ptb_mode_e m, input logic [1:0] ps,
                       input logic [3:0] os, input logic [15:0] per);
    wr(`PTB_ADDR_CONTROL, 16'h0000);
    wr(`PTB_ADDR_COUNT, 16'h0000);
    wr(`PTB_ADDR_PERIOD, per);
    wr(`PTB_ADDR_CONTROL, ctl(1'b1, m, ps, os));
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, unmapped place, read-only direction bit
    rchk(`PTB_ADDR_CONTROL, `PTB_RST_CONTROL);
    rchk(`PTB_ADDR_PERIOD, 16'h0000);
    rchk(`PTB_ADDR_INT_MASK, 16'h0000);
    wr(4'h7, 16'hffff);
    rchk(4'h7, 16'h0000);
    wr(`PTB_ADDR_COUNT, 16'h8005);
    rchk(`PTB_ADDR_COUNT, 16'h0005);
    $display("test registers done");
    // Free run, period 3: one event per four ticks
    start(PTB_FREE_RUN, 2'h0, 4'h0, 16'h0003);
    win(40, 16'h000a);
    chk({15'h0000, irq}, 16'h0000);
    wr(`PTB_ADDR_CONTROL, 16'h0000);
    rd(`PTB_ADDR_COUNT);
    chk({15'h0000, rv[15]}, 16'h0000);
    chk({15'h0000, rv[14:0] <= 15'h0003}, 16'h0001);
    repeat (10) @(posedge sys_clk);
    rchk(`PTB_ADDR_COUNT, rv);
    $display("test free_run done");
    // All prescaler ratios, period 1
    for (int k = 0; k < 4; k++) begin
      start(PTB_FREE_RUN, k[1:0], 4'h0, 16'h0001);
      win(256, 16'(128 >> (2 * k)));
    end
    // All postscaler settings
    for (int k = 0; k < 16; k++) begin
      start(PTB_FREE_RUN, 2'h0, k[3:0], 16'h0001);
      win(8 * (k + 1), 16'h0004);
    end
    $display("test scalers done");
    // Up/down: one event per six ticks; count 2 seen once each way
    start(PTB_UP_DOWN, 2'h0, 4'h0, 16'h0003);
    win(60, 16'h000a);
    up = 16'h0000;
    dn = 16'h0000;
    @(posedge sys_clk);
    reg_addr <= `PTB_ADDR_COUNT;
    reg_rd   <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      if (reg_rdata === 16'h0002) up++;
      if (reg_rdata === 16'h8002) dn++;
    end
    reg_rd <= 1'b0;
    chk(up, 16'h0001);
    chk(dn, 16'h0001);
    // Double update ignores the postscaler
    start(PTB_UP_DOWN_DBL, 2'h0, 4'h3, 16'h0003);
    win(60, 16'h0014);
    $display("test up_down done");
    // Zero period stops everything; new period only after disable
    start(PTB_FREE_RUN, 2'h0, 4'h0, 16'h0000);
    win(40, 16'h0000);
    rchk(`PTB_ADDR_COUNT, 16'h0000);
    wr(`PTB_ADDR_PERIOD, 16'h0003);
    win(40, 16'h0000);
    wr(`PTB_ADDR_CONTROL, 16'h0000);
    wr(`PTB_ADDR_CONTROL, ctl(1'b1, PTB_FREE_RUN, 2'h0, 4'h0));
    win(40, 16'h000a);
    $display("test zero_period done");
    // Single shot with unmasked interrupt
    start(PTB_FREE_RUN, 2'h0, 4'h0, 16'h0000);
    wr(`PTB_ADDR_CONTROL, 16'h0000);
    wr(`PTB_ADDR_PERIOD, 16'h0003);
    rchk(`PTB_ADDR_INT_STAT, 16'h0001);
    wr(`PTB_ADDR_INT_MASK, 16'h0001);
    win(4, 16'h0000);
    wr(`PTB_ADDR_CONTROL, ctl(1'b1, PTB_SINGLE_SHOT, 2'h0, 4'h3));
    repeat (30) @(posedge sys_clk);
    #1;
    chk(nev, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rchk(`PTB_ADDR_CONTROL, ctl(1'b0, PTB_SINGLE_SHOT, 2'h0, 4'h3));
    rchk(`PTB_ADDR_COUNT, 16'h0000);
    rchk(`PTB_ADDR_INT_STAT, 16'h0003);
    rchk(`PTB_ADDR_INT_STAT, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    $display("test single_shot done");
    tally_and_finish();
  end
endmodule
